// [hw/bic_pkg.sv]
// Shared types and constants for the branch and if-then control block
package bic_pkg;

  localparam int ADDR_W = 32;
  localparam int OFF_W = 25;
  localparam int NARROW_OFF_W = 21;
  localparam int CB_OFF_W = 7;
  localparam int IT_W = 8;

  localparam logic [3:0] COND_EQ = 4'h0;
  localparam logic [3:0] COND_NE = 4'h1;
  localparam logic [3:0] COND_CS = 4'h2;
  localparam logic [3:0] COND_CC = 4'h3;
  localparam logic [3:0] COND_MI = 4'h4;
  localparam logic [3:0] COND_PL = 4'h5;
  localparam logic [3:0] COND_VS = 4'h6;
  localparam logic [3:0] COND_VC = 4'h7;
  localparam logic [3:0] COND_HI = 4'h8;
  localparam logic [3:0] COND_LS = 4'h9;
  localparam logic [3:0] COND_GE = 4'hA;
  localparam logic [3:0] COND_LT = 4'hB;
  localparam logic [3:0] COND_GT = 4'hC;
  localparam logic [3:0] COND_LE = 4'hD;
  localparam logic [3:0] COND_AL = 4'hE;

  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;

  localparam logic [ADDR_W-1:0] PC_AHEAD = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] SIZE_NARROW = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] SIZE_WIDE = 32'h0000_0004;
  localparam logic [IT_W-1:0] IT_RESET = 8'h00;
  localparam logic [2:0] IT_LAST_SLOT = 3'h0;
  localparam logic [3:0] IT_MASK_NONE = 4'h0;

  typedef enum logic [3:0] {
    OP_OTHER = 4'b0000,
    OP_B = 4'b0001,
    OP_BCOND = 4'b0010,
    OP_BL = 4'b0011,
    OP_BX = 4'b0100,
    OP_BLX = 4'b0101,
    OP_CBZ = 4'b0110,
    OP_COMPARE_BRANCH_IF_NONZERO = 4'b0111,
    OP_IT = 4'b1000,
    OP_BREAKPOINT_INSTRUCTION = 4'b1001
  } bic_op_t;

  typedef struct packed {
    logic valid;
    bic_op_t op;
    logic [3:0] cond;
    logic [3:0] it_mask;
    logic [OFF_W-1:0] offset;
    logic [ADDR_W-1:0] rm_value;
    logic [ADDR_W-1:0] pc;
    logic wide;
  } bic_instr_t;

  typedef struct packed {
    logic branch_valid;
    logic [ADDR_W-1:0] target;
    logic link_we;
    logic [ADDR_W-1:0] link_data;
    logic usage_fault;
    logic breakpoint;
    logic flags_we;
  } bic_result_t;

endpackage : bic_pkg

// [hw/bic_cond_eval.sv]
// Condition code evaluation against the flags
`timescale 1ns/10ps
module bic_cond_eval (
  input wire logic [3:0] cond,
  input wire logic [3:0] flags,
  output logic pass
);

  logic n;
  logic z;
  logic c;
  logic v;

  always_comb begin
    n = flags[bic_pkg::FLAG_N];
    z = flags[bic_pkg::FLAG_Z];
    c = flags[bic_pkg::FLAG_C];
    v = flags[bic_pkg::FLAG_V];
    case (cond)
      bic_pkg::COND_EQ: pass = z;
      bic_pkg::COND_NE: pass = !z;
      bic_pkg::COND_CS: pass = c;
      bic_pkg::COND_CC: pass = !c;
      bic_pkg::COND_MI: pass = n;
      bic_pkg::COND_PL: pass = !n;
      bic_pkg::COND_VS: pass = v;
      bic_pkg::COND_VC: pass = !v;
      bic_pkg::COND_HI: pass = c && !z;
      bic_pkg::COND_LS: pass = !c || z;
      bic_pkg::COND_GE: pass = (n == v);
      bic_pkg::COND_LT: pass = (n != v);
      bic_pkg::COND_GT: pass = !z && (n == v);
      bic_pkg::COND_LE: pass = z || (n != v);
      // Always, and the unused code, pass
      default: pass = 1'b1;
    endcase
  end

endmodule : bic_cond_eval

// [hw/bic_branch_ctrl.sv]
// Branch group and if-then block execution logic
`timescale 1ns/10ps
// Notes on behaviour
// - Register branch target clears bit zero
// - Link forms store next instruction address
// - Register branch with bit zero clear faults
// - Conditional branch outside block reaches 1 MB
// - Conditional branch inside block reaches 16 MB
// - Compare branch tests zero, flags untouched
// - Prefix makes one to four slots conditional
// - Then keeps condition, else inverts it
// - Breakpoint in block always executes
// - Exceptions allowed around block, state saved
// - Exception return resumes partial block
module bic_branch_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire bic_pkg::bic_instr_t instr,
  input wire logic [3:0] flags,
  input wire logic exc_entry,
  input wire logic exc_return,
  input wire logic [bic_pkg::IT_W-1:0] restore_it,
  output bic_pkg::bic_result_t result,
  output logic [bic_pkg::IT_W-1:0] it_state,
  output logic [bic_pkg::IT_W-1:0] saved_it,
  output logic in_block
);

  typedef struct packed {
    logic [bic_pkg::IT_W-1:0] it;
    logic [bic_pkg::IT_W-1:0] saved;
    bic_pkg::bic_result_t res;
  } bic_state_t;

  bic_state_t state_reg;
  bic_state_t state_next;
  logic blk_active;
  logic [3:0] eff_cond;
  logic cond_pass;

  // Sign extends a branch offset, keeping only the reach of the form
  function automatic logic [bic_pkg::ADDR_W-1:0] bic_sext(
    input logic [bic_pkg::OFF_W-1:0] off,
    input logic narrow
  );
    logic [bic_pkg::ADDR_W-1:0] wide_v;
    logic [bic_pkg::ADDR_W-1:0] narrow_v;
    wide_v = {{(bic_pkg::ADDR_W-bic_pkg::OFF_W){off[bic_pkg::OFF_W-1]}}, off};
    narrow_v = {{(bic_pkg::ADDR_W-bic_pkg::NARROW_OFF_W){off[bic_pkg::NARROW_OFF_W-1]}},
                off[bic_pkg::NARROW_OFF_W-1:0]};
    return narrow ? narrow_v : wide_v;
  endfunction : bic_sext

  // Shifts the slot mask on; an empty remainder ends the block
  function automatic logic [bic_pkg::IT_W-1:0] bic_it_advance(
    input logic [bic_pkg::IT_W-1:0] it
  );
    logic [bic_pkg::IT_W-1:0] nx;
    nx = bic_pkg::IT_RESET;
    if (it[2:0] != bic_pkg::IT_LAST_SLOT) begin
      nx = {it[7:5], it[3:0], 1'b0};
    end
    return nx;
  endfunction : bic_it_advance

  function automatic logic [bic_pkg::ADDR_W-1:0] bic_next_pc(
    input bic_pkg::bic_instr_t ins
  );
    return ins.pc + (ins.wide ? bic_pkg::SIZE_WIDE : bic_pkg::SIZE_NARROW);
  endfunction : bic_next_pc

  assign blk_active = (state_reg.it[3:0] != bic_pkg::IT_MASK_NONE);

  // Inside a block the slot condition rules; outside only the conditional branch has one
  always_comb begin
    if (blk_active) begin
      eff_cond = state_reg.it[7:4];
    end else if (instr.op == bic_pkg::OP_BCOND) begin
      eff_cond = instr.cond;
    end else begin
      eff_cond = bic_pkg::COND_AL;
    end
  end

  bic_cond_eval u_cond (
    .cond(eff_cond),
    .flags(flags),
    .pass(cond_pass)
  );

  always_comb begin
    state_next = state_reg;
    state_next.res = '0;
    // Condition flags are never written by this group
    state_next.res.flags_we = 1'b0;
    if (exc_return) begin
      // Exception return is the only way back into a partly run block
      state_next.it = restore_it;
    end else if (exc_entry) begin
      state_next.saved = state_reg.it;
      state_next.it = bic_pkg::IT_RESET;
    end else if (instr.valid) begin
      if (blk_active && instr.op != bic_pkg::OP_IT) begin
        // A branch in the last slot also ends the block here
        state_next.it = bic_it_advance(state_reg.it);
      end
      case (instr.op)
        bic_pkg::OP_IT: begin
          // A nested prefix is not allowed, so it is ignored inside a block
          if (!blk_active) begin
            state_next.it = {instr.cond, instr.it_mask};
          end
        end
        bic_pkg::OP_B, bic_pkg::OP_BCOND, bic_pkg::OP_BL: begin
          if (cond_pass) begin
            state_next.res.branch_valid = 1'b1;
            // Narrow reach only for the conditional form outside a block
            state_next.res.target = instr.pc + bic_pkg::PC_AHEAD
              + bic_sext(instr.offset,
                         (instr.op == bic_pkg::OP_BCOND) && !blk_active);
            if (instr.op == bic_pkg::OP_BL) begin
              state_next.res.link_we = 1'b1;
              state_next.res.link_data = bic_next_pc(instr);
            end
          end
        end
        bic_pkg::OP_BX, bic_pkg::OP_BLX: begin
          if (cond_pass) begin
            if (!instr.rm_value[0]) begin
              state_next.res.usage_fault = 1'b1;
            end else begin
              state_next.res.branch_valid = 1'b1;
              state_next.res.target = {instr.rm_value[bic_pkg::ADDR_W-1:1], 1'b0};
              if (instr.op == bic_pkg::OP_BLX) begin
                state_next.res.link_we = 1'b1;
                state_next.res.link_data = bic_next_pc(instr);
              end
            end
          end
        end
        bic_pkg::OP_CBZ, bic_pkg::OP_COMPARE_BRANCH_IF_NONZERO: begin
          // Forward only: offset is unsigned
          if ((instr.rm_value == '0) == (instr.op == bic_pkg::OP_CBZ)) begin
            state_next.res.branch_valid = 1'b1;
            state_next.res.target = instr.pc + bic_pkg::PC_AHEAD
              + {{(bic_pkg::ADDR_W-bic_pkg::CB_OFF_W){1'b0}},
                 instr.offset[bic_pkg::CB_OFF_W-1:0]};
          end
        end
        bic_pkg::OP_BREAKPOINT_INSTRUCTION: begin
          state_next.res.breakpoint = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign result = state_reg.res;
  assign it_state = state_reg.it;
  assign saved_it = state_reg.saved;
  assign in_block = blk_active;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic past_quiet;
  assign past_quiet = !exc_entry && !exc_return;

  sequence seq_reg_branch_ok;
    past_quiet && instr.valid && cond_pass && instr.rm_value[0]
      && (instr.op == bic_pkg::OP_BX || instr.op == bic_pkg::OP_BLX);
  endsequence

  sequence seq_reg_branch_bad;
    past_quiet && instr.valid && cond_pass && !instr.rm_value[0]
      && (instr.op == bic_pkg::OP_BX || instr.op == bic_pkg::OP_BLX);
  endsequence

  sequence seq_it_load;
    past_quiet && instr.valid && instr.op == bic_pkg::OP_IT && !blk_active;
  endsequence

  chk_reg_target_even: assert property (
    seq_reg_branch_ok |=> result.branch_valid && !result.target[0]
      && result.target[31:1] == $past(instr.rm_value[31:1]))
    else $error("register branch target wrong");

  chk_link_next_addr: assert property (
    result.link_we |-> result.link_data == $past(instr.pc)
      + ($past(instr.wide) ? bic_pkg::SIZE_WIDE : bic_pkg::SIZE_NARROW))
    else $error("link address not next instruction");

  chk_fault_no_branch: assert property (
    seq_reg_branch_bad |=> result.usage_fault && !result.branch_valid && !result.link_we)
    else $error("bad register target did not fault");

  chk_narrow_reach: assert property (
    past_quiet && instr.valid && instr.op == bic_pkg::OP_BCOND && !blk_active && cond_pass
      |=> result.target == $past(instr.pc) + bic_pkg::PC_AHEAD
        + bic_sext($past(instr.offset), 1'b1))
    else $error("conditional branch outside block reach wrong");

  chk_wide_reach: assert property (
    past_quiet && instr.valid && instr.op == bic_pkg::OP_BCOND && blk_active && cond_pass
      |=> result.target == $past(instr.pc) + bic_pkg::PC_AHEAD
        + bic_sext($past(instr.offset), 1'b0))
    else $error("conditional branch inside block reach wrong");

  chk_cbz_decision: assert property (
    past_quiet && instr.valid && (instr.op == bic_pkg::OP_CBZ || instr.op == bic_pkg::OP_COMPARE_BRANCH_IF_NONZERO)
      |=> result.branch_valid == ($past(instr.rm_value == '0)
        == $past(instr.op == bic_pkg::OP_CBZ)))
    else $error("compare branch decision wrong");

  chk_it_lifetime: assert property (
    (seq_it_load and instr.it_mask[0]) ##1
      (in_block && instr.valid && past_quiet && instr.op != bic_pkg::OP_IT) [*4] |=> !in_block)
    else $error("four slot block did not end after four instructions");

  chk_else_inverts: assert property (
    in_block && instr.valid && past_quiet && instr.op != bic_pkg::OP_IT
      && state_reg.it[2:0] != bic_pkg::IT_LAST_SLOT
      |=> it_state[7:4] == {$past(state_reg.it[7:5]), $past(state_reg.it[3])})
    else $error("slot condition not advanced");

  chk_breakpoint_instruction_always: assert property (
    past_quiet && instr.valid && instr.op == bic_pkg::OP_BREAKPOINT_INSTRUCTION |=> result.breakpoint)
    else $error("breakpoint not executed");

  chk_exc_save: assert property (
    !exc_return && exc_entry |=> saved_it == $past(state_reg.it) && !in_block)
    else $error("block state not saved on exception");

  chk_exc_restore: assert property (
    exc_return |=> it_state == $past(restore_it))
    else $error("block state not restored");

  chk_flags_kept: assert property (
    result.branch_valid || result.link_we |-> !result.flags_we)
    else $error("branch wrote flags");

  chk_block_clear: assert property (
    in_block && instr.valid && past_quiet && instr.op != bic_pkg::OP_IT
      && it_state[2:0] == bic_pkg::IT_LAST_SLOT |=> !in_block)
    else $error("block did not end after last slot");

  // A prefix met inside a block must leave the running block alone
  chk_nested_ignored: assert property (
    in_block && instr.valid && past_quiet && instr.op == bic_pkg::OP_IT
      |=> it_state == $past(it_state))
    else $error("prefix inside block changed block state");

  chk_idle_holds: assert property (
    !instr.valid && past_quiet
      |=> it_state == $past(it_state) && !result.branch_valid && !result.link_we)
    else $error("idle slot changed block state");

  chk_fail_no_branch: assert property (
    past_quiet && instr.valid && !cond_pass
      && (instr.op == bic_pkg::OP_B || instr.op == bic_pkg::OP_BCOND
        || instr.op == bic_pkg::OP_BL || instr.op == bic_pkg::OP_BX
        || instr.op == bic_pkg::OP_BLX)
      |=> !result.branch_valid && !result.link_we && !result.usage_fault)
    else $error("failed condition still branched");

  // Instructions offered with an exception edge are dropped, not executed
  chk_exc_refuse: assert property (
    exc_entry || exc_return
      |=> !result.branch_valid && !result.breakpoint && !result.usage_fault)
    else $error("instruction executed during exception change");

  chk_cb_target: assert property (
    past_quiet && instr.valid && (instr.op == bic_pkg::OP_CBZ || instr.op == bic_pkg::OP_COMPARE_BRANCH_IF_NONZERO)
      && ((instr.rm_value == '0) == (instr.op == bic_pkg::OP_CBZ))
      |=> result.target == $past(instr.pc) + bic_pkg::PC_AHEAD
        + 32'($past(instr.offset[bic_pkg::CB_OFF_W-1:0])))
    else $error("compare branch target wrong");

  chk_breakpoint_instruction_only: assert property (
    past_quiet && instr.valid && instr.op == bic_pkg::OP_BREAKPOINT_INSTRUCTION
      |=> !result.branch_valid && !result.link_we && !result.usage_fault)
    else $error("breakpoint did more than break");

  chk_no_link: assert property (
    past_quiet && instr.valid && (instr.op == bic_pkg::OP_B || instr.op == bic_pkg::OP_BCOND
      || instr.op == bic_pkg::OP_BX) |=> !result.link_we)
    else $error("plain branch wrote link register");

endmodule : bic_branch_ctrl

// [tb/bic_stream_model.sv]
// Instruction stream model feeding the branch block
`timescale 1ns/10ps
module bic_stream_model (
  input wire logic clk,
  input wire logic reset_n,
  output bic_pkg::bic_instr_t instr
);
  // Nothing is offered until reset is released
  // Edge-driven so the bus is clean even if the first reset edge is missed
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instr <= '0;
    end
  end
  // Caller times each call to a rising edge of clk
  task automatic put(input bic_pkg::bic_instr_t ins);
    instr <= ins;
  endtask : put
  // Idle slots scramble the fields so stale data never looks like a repeat
  task automatic idle;
    bic_pkg::bic_instr_t n;
    n = ~instr;
    n.valid = 1'b0;
    instr <= n;
  endtask : idle
endmodule : bic_stream_model

// [tb/bic_branch_ctrl_tb.sv]
// Self-checking testbench for the branch and if-then control block
`timescale 1ns/10ps
module bic_branch_ctrl_tb;
  logic clk;
  logic reset_n;
  bic_pkg::bic_instr_t instr;
  logic [3:0] flags;
  logic exc_entry;
  logic exc_return;
  logic [7:0] restore_it;
  bic_pkg::bic_result_t result;
  logic [7:0] it_state;
  logic [7:0] saved_it;
  logic in_block;
  int errors;
  int num_checks;
  localparam logic [31:0] P = 32'h0000_2000;

  bic_stream_model bic_stream_model_i (.clk(clk), .reset_n(reset_n), .instr(instr));
  bic_branch_ctrl bic_branch_ctrl_i (.clk(clk), .reset_n(reset_n), .instr(instr),
    .flags(flags), .exc_entry(exc_entry), .exc_return(exc_return),
    .restore_it(restore_it), .result(result), .it_state(it_state),
    .saved_it(saved_it), .in_block(in_block));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic bic_pkg::bic_instr_t mk(input bic_pkg::bic_op_t op,
      input logic [3:0] cond, input logic [3:0] mask, input logic [24:0] off,
      input logic [31:0] rm, input logic wide);
    mk = '{valid:1'b1, op:op, cond:cond, it_mask:mask, offset:off, rm_value:rm, pc:P,
      wide:wide};
  endfunction : mk

  // One instruction, then an idle slot; result is settled on return
  task automatic run(input bic_pkg::bic_instr_t ins, input logic [3:0] fl);
    @(posedge clk);
    flags <= fl;
    bic_stream_model_i.put(ins);
    @(posedge clk);
    bic_stream_model_i.idle();
    #1;
  endtask : run

  task automatic br(input logic bv, input logic [31:0] tgt);
    chk("branch_valid", result.branch_valid, bv);
    chk("target", result.target, tgt);
    chk("flags_we", result.flags_we, 1'b0);
  endtask : br

  task automatic t_imm;
    run(mk(bic_pkg::OP_B, bic_pkg::COND_NE, 4'h0, 25'h1F0_0000, 32'h0, 1'b1), 4'h4);
    br(1'b1, P + bic_pkg::PC_AHEAD + 32'hFFF0_0000);
    run(mk(bic_pkg::OP_BCOND, bic_pkg::COND_EQ, 4'h0, 25'h0F0_0000, 32'h0, 1'b1), 4'h4);
    br(1'b1, P + bic_pkg::PC_AHEAD + 32'hFFF0_0000);
    run(mk(bic_pkg::OP_BCOND, bic_pkg::COND_NE, 4'h0, 25'h000_0100, 32'h0, 1'b1), 4'h4);
    br(1'b0, 32'h0);
    run(mk(bic_pkg::OP_BL, bic_pkg::COND_AL, 4'h0, 25'h000_0100, 32'h0, 1'b1), 4'h4);
    br(1'b1, P + bic_pkg::PC_AHEAD + 32'h100);
    chk("link_data", result.link_data, P + bic_pkg::SIZE_WIDE);
    $display("t_imm done");
  endtask : t_imm

  task automatic t_reg;
    run(mk(bic_pkg::OP_BX, bic_pkg::COND_AL, 4'h0, 25'h0, 32'h8000_1235, 1'b0), 4'h0);
    br(1'b1, 32'h8000_1234);
    chk("link_we", result.link_we, 1'b0);
    run(mk(bic_pkg::OP_BLX, bic_pkg::COND_AL, 4'h0, 25'h0, 32'h0000_4001, 1'b0), 4'h0);
    br(1'b1, 32'h0000_4000);
    chk("link_data", result.link_data, P + bic_pkg::SIZE_NARROW);
    run(mk(bic_pkg::OP_BLX, bic_pkg::COND_AL, 4'h0, 25'h0, 32'h0000_4000, 1'b0), 4'h0);
    br(1'b0, 32'h0);
    chk("usage_fault", result.usage_fault, 1'b1);
    chk("link_we", result.link_we, 1'b0);
    $display("t_reg done");
  endtask : t_reg

  task automatic t_cb;
    run(mk(bic_pkg::OP_CBZ, bic_pkg::COND_AL, 4'h0, 25'h1FF_FFFE, 32'h0, 1'b0), 4'h0);
    br(1'b1, P + 32'd130);
    run(mk(bic_pkg::OP_CBZ, bic_pkg::COND_AL, 4'h0, 25'h0, 32'h5, 1'b0), 4'h4);
    br(1'b0, 32'h0);
    run(mk(bic_pkg::OP_COMPARE_BRANCH_IF_NONZERO, bic_pkg::COND_AL, 4'h0, 25'h0, 32'h5, 1'b0), 4'h4);
    br(1'b1, P + 32'd4);
    run(mk(bic_pkg::OP_COMPARE_BRANCH_IF_NONZERO, bic_pkg::COND_AL, 4'h0, 25'h0, 32'h0, 1'b0), 4'h0);
    br(1'b0, 32'h0);
    $display("t_cb done");
  endtask : t_cb

  // Every condition code but AL against two flag sets; bit n is the verdict for code n
  task automatic t_cond;
    logic [13:0] exp_a;
    logic [13:0] exp_b;
    exp_a = 14'h165A;
    exp_b = 14'h26A5;
    for (int c = 0; c < 14; c++) begin
      run(mk(bic_pkg::OP_BCOND, 4'(c), 4'h0, 25'h0, 32'h0, 1'b0), 4'h9);
      chk("cond_pass_a", result.branch_valid, exp_a[c]);
      run(mk(bic_pkg::OP_BCOND, 4'(c), 4'h0, 25'h0, 32'h0, 1'b0), 4'h6);
      chk("cond_pass_b", result.branch_valid, exp_b[c]);
    end
    $display("t_cond done");
  endtask : t_cond

  task automatic t_it;
    run(mk(bic_pkg::OP_IT, bic_pkg::COND_EQ, 4'hC, 25'h0, 32'h0, 1'b0), 4'h0);
    chk("it_state", it_state, 8'h0C);
    chk("in_block", in_block, 1'b1);
    run(mk(bic_pkg::OP_OTHER, bic_pkg::COND_EQ, 4'h0, 25'h0, 32'h0, 1'b0), 4'h0);
    chk("it_state", it_state, 8'h18);
    run(mk(bic_pkg::OP_BCOND, bic_pkg::COND_NE, 4'h0, 25'h100_0000, 32'h0, 1'b1), 4'h0);
    br(1'b1, P + bic_pkg::PC_AHEAD + 32'hFF00_0000);
    chk("in_block", in_block, 1'b0);
    // Four slots back to back, then a failing branch in the last one
    @(posedge clk);
    flags <= 4'h4;
    bic_stream_model_i.put(mk(bic_pkg::OP_IT, bic_pkg::COND_NE, 4'hF, 25'h0, 32'h0, 1'b0));
    repeat (3) begin
      @(posedge clk);
      bic_stream_model_i.put(mk(bic_pkg::OP_OTHER, bic_pkg::COND_NE, 4'h0, 25'h0, 32'h0, 1'b0));
    end
    run(mk(bic_pkg::OP_B, bic_pkg::COND_NE, 4'h0, 25'h40, 32'h0, 1'b1), 4'h4);
    br(1'b0, 32'h0);
    chk("in_block", in_block, 1'b0);
    run(mk(bic_pkg::OP_IT, bic_pkg::COND_EQ, 4'h8, 25'h0, 32'h0, 1'b0), 4'h0);
    run(mk(bic_pkg::OP_BREAKPOINT_INSTRUCTION, bic_pkg::COND_EQ, 4'h0, 25'h0, 32'h0, 1'b0), 4'h0);
    chk("breakpoint", result.breakpoint, 1'b1);
    chk("in_block", in_block, 1'b0);
    $display("t_it done");
  endtask : t_it

  task automatic t_exc;
    run(mk(bic_pkg::OP_IT, bic_pkg::COND_EQ, 4'h2, 25'h0, 32'h0, 1'b0), 4'h4);
    run(mk(bic_pkg::OP_OTHER, bic_pkg::COND_EQ, 4'h0, 25'h0, 32'h0, 1'b0), 4'h4);
    @(posedge clk);
    exc_entry <= 1'b1;
    bic_stream_model_i.put(mk(bic_pkg::OP_B, bic_pkg::COND_EQ, 4'h0, 25'h8, 32'h0, 1'b0));
    @(posedge clk);
    exc_entry <= 1'b0;
    bic_stream_model_i.idle();
    #1;
    chk("saved_it", saved_it, 8'h04);
    chk("it_state", it_state, 8'h00);
    br(1'b0, 32'h0);
    @(posedge clk);
    exc_return <= 1'b1;
    restore_it <= 8'h04;
    @(posedge clk);
    exc_return <= 1'b0;
    #1;
    chk("it_state", it_state, 8'h04);
    run(mk(bic_pkg::OP_OTHER, bic_pkg::COND_EQ, 4'h0, 25'h0, 32'h0, 1'b0), 4'h4);
    run(mk(bic_pkg::OP_BCOND, bic_pkg::COND_EQ, 4'h0, 25'h40, 32'h0, 1'b1), 4'h4);
    br(1'b1, P + bic_pkg::PC_AHEAD + 32'h40);
    chk("in_block", in_block, 1'b0);
    $display("t_exc done");
  endtask : t_exc

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // Hang guard: the whole sequence needs far fewer cycles than this
  initial begin
    #200000;
    errors++;
    $display("[ERR] run expected done seen timeout");
    final_report();
  end

  initial begin
    errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    flags = 4'h0;
    exc_entry = 1'b0;
    exc_return = 1'b0;
    restore_it = 8'h00;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk("it_state", it_state, 8'h00);
    chk("saved_it", saved_it, 8'h00);
    br(1'b0, 32'h0);
    t_imm();
    t_reg();
    t_cb();
    t_cond();
    t_it();
    t_exc();
    final_report();
  end
endmodule : bic_branch_ctrl_tb
